// [rtl/scc_regs.sv]
// System control register bank: control word, cachable and bufferable areas.
//
// Behaviour
// - Instruction load mode sends stores to instruction memory.
// - Instruction memory enable routes fetches and data there.
// - Instruction memory enable resets from its init pin.
// - Data load mode sends stores to data memory.
// - Data memory enable wins over cache and bus.
// - Bit 15 clear lets loaded bit0 pick state.
// - Bit 14 picks round-robin, else pseudo-random replacement.
// - Bit 13 picks vector base low or high.
// - Vector bit resets from its init pin.
// - Instruction cache needs both bits 12 and 0.
// - Software never enables caches when cache size zero.
// - Bit 7 selects big-endian, clear little-endian.
// - Data cache needs both bits 2 and 0.
// - Bit 0 clear disables protection, caches, write buffer.
// - Software programs a region before enabling protection.
// - Register 2 selector 0 data, 1 instruction.
// - Cachable registers hold eight per-area bits.
// - Bufferable register holds eight data-only area bits.
// - Bufferable register is register 3, selector 0.
// - Control word is register 1, selector 0.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`include "scc_map.svh"
module scc_regs #(
   parameter int AREAS = 8
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   scc_if.device                     cp,
   input  wire logic                 imem_enable_init_pin,
   input  wire logic                 high_vector_init_pin,
   input  wire logic                 fetch_in_itcm,
   input  wire logic                 data_in_itcm,
   input  wire logic                 data_in_dtcm,
   input  wire logic                 data_is_store,
   input  wire logic                 pc_load,
   input  wire logic                 pc_load_bit0,
   output logic                      fetch_from_itcm,
   output scc_pkg::scc_route_t       data_route,
   output logic                      enter_compressed,
   output logic                      round_robin,
   output logic [31:0]               vector_base,
   output logic                      icache_active,
   output logic                      dcache_active,
   output logic                      big_endian,
   output logic                      protection_active,
   output logic                      write_buffer_active,
   output logic [AREAS-1:0]          data_cachable,
   output logic [AREAS-1:0]          instr_cachable,
   output logic [AREAS-1:0]          data_bufferable,
   output logic                      init_done
);
   // The area decode is fixed at eight bits per register, so refuse any other size.
   if (AREAS != 8) begin : g_areas_check
      $error("scc_regs serves exactly eight memory areas");
   end

   logic [31:0]      ctrl;
   logic [AREAS-1:0] dcach;
   logic [AREAS-1:0] icach;
   logic [AREAS-1:0] dbuf;
   logic             imem_pin_meta;
   logic             imem_pin_sync;
   logic             hvec_pin_meta;
   logic             hvec_pin_sync;
   logic [1:0]       init_cnt;
   logic             ack_q;
   logic             err_q;
   logic [31:0]      rdata_q;

   // Straps pass two sync flops and reach ctrl on the third clock after release; an async reset may only load constants.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imem_pin_meta <= 1'b0;
         imem_pin_sync <= 1'b0;
         hvec_pin_meta <= 1'b0;
         hvec_pin_sync <= 1'b0;
      end else begin
         imem_pin_meta <= imem_enable_init_pin;
         imem_pin_sync <= imem_pin_meta;
         hvec_pin_meta <= high_vector_init_pin;
         hvec_pin_sync <= hvec_pin_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_cnt <= 2'h0;
      end else if (init_cnt != `SCC_INIT_CYCLES) begin
         init_cnt <= init_cnt + 2'h1;
      end
   end

   wire init_load = (init_cnt == `SCC_INIT_CYCLES) && !init_done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_done <= 1'b0;
      end else if (init_load) begin
         init_done <= 1'b1;
      end
   end

   // Transfer decode; the core holds req until it sees ack.
   wire take      = cp.req && init_done && !ack_q;
   wire op2_zero  = (cp.op2 == `SCC_OP2_DATA);
   wire hit_ctrl  = (cp.crn == `SCC_CRN_CONTROL) && op2_zero;
   wire hit_dcach = (cp.crn == `SCC_CRN_CACHABLE) && op2_zero;
   wire hit_icach = (cp.crn == `SCC_CRN_CACHABLE) && (cp.op2 == `SCC_OP2_INSTR);
   wire hit_dbuf  = (cp.crn == `SCC_CRN_BUFFERABLE) && op2_zero;
   wire hit_any   = hit_ctrl || hit_dcach || hit_icach || hit_dbuf;
   wire wr_take   = take && cp.write;

   // Reserved bits keep their fixed value whatever is written.
   wire [31:0] ctrl_wr  = (cp.wdata & `SCC_CTRL_WMASK) | `SCC_CTRL_SBO;
   wire [31:0] ctrl_rd  = ctrl;
   wire [31:0] dcach_rd = {{(32 - AREAS){1'b0}}, dcach};
   wire [31:0] icach_rd = {{(32 - AREAS){1'b0}}, icach};
   wire [31:0] dbuf_rd  = {{(32 - AREAS){1'b0}}, dbuf};
   wire [31:0] rd_sel   = hit_ctrl  ? ctrl_rd  :
                          hit_dcach ? dcach_rd :
                          hit_icach ? icach_rd :
                          hit_dbuf  ? dbuf_rd  : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SCC_CTRL_RESET | `SCC_CTRL_SBO;
      end else if (init_load) begin
         ctrl[`SCC_BIT_ITCM_EN]  <= imem_pin_sync;
         ctrl[`SCC_BIT_HIGH_VEC] <= hvec_pin_sync;
      end else if (wr_take && hit_ctrl) begin
         ctrl <= ctrl_wr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcach <= `SCC_AREA_RESET;
         icach <= `SCC_AREA_RESET;
         dbuf  <= `SCC_AREA_RESET;
      end else if (wr_take) begin
         if (hit_dcach) begin
            dcach <= cp.wdata[AREAS-1:0];
         end
         if (hit_icach) begin
            icach <= cp.wdata[AREAS-1:0];
         end
         if (hit_dbuf) begin
            dbuf <= cp.wdata[AREAS-1:0];
         end
      end
   end

   // Answer one cycle after the request is taken; reads return the current register value, writes return zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= take;
         if (take) begin
            err_q   <= !hit_any;
            rdata_q <= cp.write ? 32'h00000000 : rd_sel;
         end
      end
   end

   assign cp.ack   = ack_q;
   assign cp.err   = err_q;
   assign cp.rdata = rdata_q;

   // Decoded controls.
   wire prot_on   = ctrl[`SCC_BIT_PROT_EN];
   wire itcm_en   = ctrl[`SCC_BIT_ITCM_EN];
   wire itcm_load = ctrl[`SCC_BIT_ITCM_LOAD];
   wire dtcm_en   = ctrl[`SCC_BIT_DTCM_EN];
   wire dtcm_load = ctrl[`SCC_BIT_DTCM_LOAD];

   assign protection_active   = prot_on;
   assign write_buffer_active = prot_on;
   assign icache_active       = ctrl[`SCC_BIT_ICACHE_EN] && prot_on;
   assign dcache_active       = ctrl[`SCC_BIT_DCACHE_EN] && prot_on;
   assign round_robin         = ctrl[`SCC_BIT_ROUND_ROBIN];
   assign big_endian          = ctrl[`SCC_BIT_BIG_ENDIAN];
   assign vector_base = ctrl[`SCC_BIT_HIGH_VEC] ? `SCC_VEC_HIGH : `SCC_VEC_LOW;
   assign enter_compressed = pc_load && pc_load_bit0 && !ctrl[`SCC_BIT_NO_PCSTATE];

   // Caches and the write buffer only see attributes while protection is on.
   assign data_cachable   = prot_on ? dcach : `SCC_AREA_RESET;
   assign instr_cachable  = prot_on ? icach : `SCC_AREA_RESET;
   assign data_bufferable = prot_on ? dbuf  : `SCC_AREA_RESET;

   // In load mode a load bypasses the memory it is filling so the copy source is read.
   wire itcm_load_sel = itcm_load && data_in_itcm;
   wire dtcm_load_sel = dtcm_load && data_in_dtcm;
   wire to_dtcm = data_in_dtcm && (data_is_store ? (dtcm_en || dtcm_load) : dtcm_en && !dtcm_load);
   wire to_itcm = data_in_itcm && (data_is_store ? (itcm_en || itcm_load) : itcm_en && !itcm_load);

   assign fetch_from_itcm = fetch_in_itcm && itcm_en;

   always_comb begin
      data_route = scc_pkg::SCC_ROUTE_EXTERNAL;
      if (to_dtcm) begin
         data_route = scc_pkg::SCC_ROUTE_DTCM;
      end else if (to_itcm) begin
         data_route = scc_pkg::SCC_ROUTE_ITCM;
      end else if (itcm_load_sel || dtcm_load_sel) begin
         data_route = scc_pkg::SCC_ROUTE_EXTERNAL;
      end
   end
endmodule

// [rtl/scc_map.svh]
// Bit positions, selector codes, offsets and reset values of the control bank.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_BIT_ITCM_LOAD   19
`define SCC_BIT_ITCM_EN     18
`define SCC_BIT_DTCM_LOAD   17
`define SCC_BIT_DTCM_EN     16
`define SCC_BIT_NO_PCSTATE  15
`define SCC_BIT_ROUND_ROBIN 14
`define SCC_BIT_HIGH_VEC    13
`define SCC_BIT_ICACHE_EN   12
`define SCC_BIT_BIG_ENDIAN  7
`define SCC_BIT_DCACHE_EN   2
`define SCC_BIT_PROT_EN     0
`define SCC_CTRL_WMASK      32'h000FF085
`define SCC_CTRL_SBO        32'h00000078
`define SCC_CTRL_RESET      32'h00000000
`define SCC_AREA_RESET      8'h00
`define SCC_VEC_LOW         32'h00000000
`define SCC_VEC_HIGH        32'hFFFF0000
`define SCC_CRN_CONTROL     4'h1
`define SCC_CRN_CACHABLE    4'h2
`define SCC_CRN_BUFFERABLE  4'h3
`define SCC_OP2_DATA        3'h0
`define SCC_OP2_INSTR       3'h1
`define SCC_INIT_CYCLES     2'h2
`define SCC_APB_CMD         12'h000
`define SCC_APB_WDATA       12'h004
`define SCC_APB_RDATA       12'h008
`define SCC_APB_STATUS      12'h00C
`define SCC_CMD_CRN_LSB     0
`define SCC_CMD_OP2_LSB     4
`define SCC_CMD_WRITE       8
`define SCC_CMD_GO          31
`define SCC_ST_BUSY         0
`define SCC_ST_DONE         1
`define SCC_ST_ERR          2
`endif

// [rtl/scc_pkg.sv]
// Types shared by both ends of the system control bank.
package scc_pkg;
   typedef enum logic [1:0] {
      SCC_ROUTE_EXTERNAL,
      SCC_ROUTE_ITCM,
      SCC_ROUTE_DTCM
   } scc_route_t;
   typedef enum logic {
      SCC_HOST_IDLE,
      SCC_HOST_WAIT
   } scc_host_state_t;
endpackage

// [rtl/scc_if.sv]
// Coprocessor register transfer link between the core and the control bank.
`timescale 1ns/100ps
interface scc_if;
   logic        req;
   logic        write;
   logic [3:0]  crn;
   logic [2:0]  op2;
   logic [31:0] wdata;
   logic        ack;
   logic        err;
   logic [31:0] rdata;
   modport device (
      input  req,
      input  write,
      input  crn,
      input  op2,
      input  wdata,
      output ack,
      output err,
      output rdata
   );
   modport core (
      output req,
      output write,
      output crn,
      output op2,
      output wdata,
      input  ack,
      input  err,
      input  rdata
   );
endinterface

// [rtl/scc_core_port.sv]
// Core end: APB command registers that issue coprocessor register transfers.
`timescale 1ns/100ps
`include "scc_map.svh"
module scc_core_port (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   scc_if.core              cp
);
   scc_pkg::scc_host_state_t state;
   logic                     req_q;
   logic                     write_q;
   logic [3:0]               crn_q;
   logic [2:0]               op2_q;
   logic [31:0]              wdata_q;
   logic [31:0]              rdata_q;
   logic                     done_q;
   logic                     err_q;

   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire hit_cmd  = (paddr == `SCC_APB_CMD);
   wire hit_wd   = (paddr == `SCC_APB_WDATA);
   wire hit_rd   = (paddr == `SCC_APB_RDATA);
   wire hit_st   = (paddr == `SCC_APB_STATUS);
   wire hit_any  = hit_cmd || hit_wd || hit_rd || hit_st;
   wire busy     = (state == scc_pkg::SCC_HOST_WAIT);
   // A start while busy is dropped; software polls busy first.
   wire start    = wr && hit_cmd && pwdata[`SCC_CMD_GO] && !busy;
   wire finish   = busy && cp.ack;
   wire done_clr = wr && hit_st && pwdata[`SCC_ST_DONE];
   wire [31:0] cmd_rd = {23'h000000, write_q, 1'b0, op2_q, crn_q};
   wire [31:0] st_rd  = {29'h00000000, err_q, done_q, busy};

   assign pready  = 1'b1;
   assign pslverr = acc && !hit_any;
   assign prdata  = hit_cmd ? cmd_rd  :
                    hit_wd  ? wdata_q :
                    hit_rd  ? rdata_q :
                    hit_st  ? st_rd   : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= scc_pkg::SCC_HOST_IDLE;
         req_q   <= 1'b0;
         write_q <= 1'b0;
         crn_q   <= 4'h0;
         op2_q   <= 3'h0;
         wdata_q <= 32'h00000000;
         rdata_q <= 32'h00000000;
         done_q  <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         if (wr && hit_wd && !busy) begin
            wdata_q <= pwdata;
         end
         // A completion in the same cycle as a clear keeps done set.
         done_q <= finish || (done_q && !done_clr);
         case (state)
            scc_pkg::SCC_HOST_IDLE: begin
               if (start) begin
                  crn_q   <= pwdata[`SCC_CMD_CRN_LSB +: 4];
                  op2_q   <= pwdata[`SCC_CMD_OP2_LSB +: 3];
                  write_q <= pwdata[`SCC_CMD_WRITE];
                  req_q   <= 1'b1;
                  state   <= scc_pkg::SCC_HOST_WAIT;
               end
            end
            scc_pkg::SCC_HOST_WAIT: begin
               if (cp.ack) begin
                  req_q <= 1'b0;
                  err_q <= cp.err;
                  if (!write_q) begin
                     rdata_q <= cp.rdata;
                  end
                  state <= scc_pkg::SCC_HOST_IDLE;
               end
            end
            default: begin
               state <= scc_pkg::SCC_HOST_IDLE;
            end
         endcase
      end
   end

   assign cp.req   = req_q;
   assign cp.write = write_q;
   assign cp.crn   = crn_q;
   assign cp.op2   = op2_q;
   assign cp.wdata = wdata_q;
endmodule

// [tb/scc_chk.sv]
// Link checker for the coprocessor transfer path between the two ends.
`timescale 1ns/100ps
module scc_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        req,
   input wire logic        write,
   input wire logic [3:0]  crn,
   input wire logic [2:0]  op2,
   input wire logic [31:0] wdata,
   input wire logic        ack,
   input wire logic        err,
   input wire logic [31:0] rdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd_area = req & !write & (crn == 4'h2 | crn == 4'h3);
   wire logic rd_ctrl = req & !write & crn == 4'h1;
   wire logic no_reg  = req & (crn == 4'h0 | crn > 4'h3);

   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
      else $error("ack without a pending request");
   unmapped_err_a: assert property (ack && $past(no_reg) |-> err)
      else $error("unmapped register answered without error");
   cach_sel_a: assert property (ack && $past(req && crn == 4'h2) |-> err == ($past(op2) > 3'h1))
      else $error("cachable selector decoded wrongly");
   buf_sel_a: assert property (ack && $past(req && crn == 4'h3) |-> err == ($past(op2) != 3'h0))
      else $error("bufferable selector decoded wrongly");
   area_high_a: assert property (ack && $past(rd_area) |-> rdata[31:8] == 24'h000000)
      else $error("area register read nonzero above bit 7");
   ctrl_rsv_a: assert property (ack && $past(rd_ctrl) && !err |->
      rdata[31:20] == 12'h000 && rdata[11:8] == 4'h0 && rdata[6:3] == 4'hF && !rdata[1])
      else $error("control word reserved bits read wrongly");
   rdata_hold_a: assert property (!req |=> $stable(rdata) && $stable(err))
      else $error("read result changed without a transfer");
endmodule

// [tb/system_control_cache_attr_regs_tb_top.sv]
// Bench joining the core end and the register bank, driven over APB.
`timescale 1ns/100ps
`include "scc_map.svh"
module system_control_cache_attr_regs_tb_top;
   logic                pclk = 1'h0;
   logic                presetn = 1'h0;
   logic                psel = 1'h0;
   logic                penable = 1'h0;
   logic                pwrite = 1'h0;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h00000000;
   logic                imem_enable_init_pin = 1'h1;
   logic                high_vector_init_pin = 1'h1;
   logic [5:0]          sv = 6'h00;
   wire  logic [31:0]   prdata;
   wire  logic          pready;
   wire  logic          pslverr;
   wire  logic          fetch_from_itcm;
   scc_pkg::scc_route_t data_route;
   wire  logic          enter_compressed;
   wire  logic          round_robin;
   wire  logic [31:0]   vector_base;
   wire  logic          icache_active;
   wire  logic          dcache_active;
   wire  logic          big_endian;
   wire  logic          protection_active;
   wire  logic          write_buffer_active;
   wire  logic [7:0]    data_cachable;
   wire  logic [7:0]    instr_cachable;
   wire  logic [7:0]    data_bufferable;
   wire  logic          init_done;
   logic [31:0]         rd;
   logic                er;
   logic                slv;
   int                  num_errors = 0;
   int                  num_checks = 0;

   always #2 pclk = ~pclk;
   scc_if link ();
   scc_core_port i_scc_core_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cp(link.core));
   scc_regs i_scc_regs (.pclk, .presetn, .cp(link.device), .imem_enable_init_pin,
      .high_vector_init_pin, .fetch_in_itcm(sv[5]), .data_in_itcm(sv[4]),
      .data_in_dtcm(sv[3]), .data_is_store(sv[2]), .pc_load(sv[1]), .pc_load_bit0(sv[0]),
      .fetch_from_itcm, .data_route, .enter_compressed, .round_robin, .vector_base,
      .icache_active, .dcache_active, .big_endian, .protection_active, .write_buffer_active,
      .data_cachable, .instr_cachable, .data_bufferable, .init_done);
   scc_chk i_scc_chk (.pclk, .presetn, .req(link.req), .write(link.write), .crn(link.crn),
      .op2(link.op2), .wdata(link.wdata), .ack(link.ack), .err(link.err), .rdata(link.rdata));

   task automatic finish_test();
      if (num_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Issues one link transfer; the read result lands in rd and the error flag in er.
   task automatic cp(input logic w, input logic [3:0] n, input logic [2:0] o,
      input logic [31:0] d);
      apb(1'h1, `SCC_APB_WDATA, d);
      apb(1'h1, `SCC_APB_CMD, {1'h1, 22'h000000, w, 1'h0, o, n});
      // Only the watchdog ends a hung transfer; a local limit would hide it.
      do begin
         apb(1'h0, `SCC_APB_STATUS, 32'h00000000);
      end while (rd[1] !== 1'h1);
      er = rd[2];
      apb(1'h1, `SCC_APB_STATUS, 32'h00000002);
      apb(1'h0, `SCC_APB_RDATA, 32'h00000000);
   endtask

   task automatic side(input logic [5:0] v);
      @(posedge pclk);
      sv <= v;
      @(posedge pclk);
   endtask

   task automatic rt(input logic [31:0] c, input logic [5:0] s, input logic [1:0] e);
      cp(1'h1, 4'h1, 3'h0, c | `SCC_CTRL_SBO);
      side(s);
      chk("route", 32'(data_route), 32'(e));
   endtask

   // The straps are only sampled a few edges after release, so wait for init_done.
   task automatic t_reset(input logic [31:0] ctrl, input logic [31:0] vec);
      while (init_done !== 1'h1) begin
         @(posedge pclk);
      end
      cp(1'h0, 4'h1, 3'h0, 32'h00000000);
      chk("ctrl_reset", rd, ctrl);
      chk("vec_reset", vector_base, vec);
      cp(1'h0, 4'h3, 3'h0, 32'h00000000);
      chk("buf_reset", rd, 32'h00000000);
      side(6'h20);
      chk("fetch_itcm", 32'(fetch_from_itcm), 32'(ctrl[18]));
   endtask

   task automatic t_ctrl();
      // Both caches exist in this system, so setting their enables is legal.
      cp(1'h1, 4'h1, 3'h0, 32'h000FF0FD);
      cp(1'h0, 4'h1, 3'h0, 32'h00000000);
      chk("ctrl_all", rd, 32'h000FF0FD);
      side(6'h0B);
      chk("all_on", 32'({icache_active, dcache_active, round_robin, big_endian,
         enter_compressed}), 32'h0000001E);
      chk("vec_high", vector_base, `SCC_VEC_HIGH);
      rt(32'h00010000, 6'h08, scc_pkg::SCC_ROUTE_DTCM);
      rt(32'h00020000, 6'h0C, scc_pkg::SCC_ROUTE_DTCM);
      rt(32'h00020000, 6'h08, scc_pkg::SCC_ROUTE_EXTERNAL);
      rt(32'h00080000, 6'h14, scc_pkg::SCC_ROUTE_ITCM);
      rt(32'h00080000, 6'h10, scc_pkg::SCC_ROUTE_EXTERNAL);
      rt(32'h00040000, 6'h10, scc_pkg::SCC_ROUTE_ITCM);
      rt(32'h00000000, 6'h1C, scc_pkg::SCC_ROUTE_EXTERNAL);
      cp(1'h1, 4'h1, 3'h0, 32'h0000007D);
      side(6'h03);
      chk("d_only", 32'({icache_active, dcache_active, protection_active, write_buffer_active,
         enter_compressed, round_robin, big_endian}), 32'h0000003C);
      chk("vec_low", vector_base, `SCC_VEC_LOW);
      cp(1'h1, 4'h1, 3'h0, 32'h00001078);
      side(6'h00);
      chk("i_no_prot", 32'({icache_active, protection_active, write_buffer_active}),
         32'h00000000);
   endtask

   task automatic t_areas();
      // Region registers sit outside this bank; the core has set one up already.
      cp(1'h1, 4'h1, 3'h0, 32'h00000079);
      cp(1'h1, 4'h2, 3'h0, 32'hFFFFFFA5);
      cp(1'h1, 4'h2, 3'h1, 32'h0000003C);
      cp(1'h1, 4'h3, 3'h0, 32'h123456C3);
      cp(1'h0, 4'h2, 3'h0, 32'h00000000);
      chk("dcach", rd, 32'h000000A5);
      cp(1'h0, 4'h2, 3'h1, 32'h00000000);
      chk("icach", rd, 32'h0000003C);
      cp(1'h0, 4'h3, 3'h0, 32'h00000000);
      chk("dbuf", rd, 32'h000000C3);
      chk("areas", {8'h00, data_cachable, instr_cachable, data_bufferable},
         32'h00A53CC3);
      cp(1'h1, 4'h1, 3'h0, 32'h00000078);
      chk("masked", {8'h00, data_cachable, instr_cachable, data_bufferable}, 32'h00000000);
      cp(1'h1, 4'h4, 3'h0, 32'h00000001);
      chk("err_crn", 32'(er), 32'h00000001);
      cp(1'h1, 4'h2, 3'h2, 32'h000000FF);
      chk("err_op2", 32'(er), 32'h00000001);
      cp(1'h1, 4'h3, 3'h1, 32'h000000FF);
      chk("err_buf", 32'(er), 32'h00000001);
      cp(1'h0, 4'h3, 3'h0, 32'h00000000);
      chk("dbuf_kept", {rd[30:0], er}, 32'h00000186);
      apb(1'h1, 12'h010, 32'h00000000);
      chk("slverr", 32'(slv), 32'h00000001);
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_reset(32'h00042078, `SCC_VEC_HIGH);
      t_ctrl();
      t_areas();
      @(posedge pclk);
      presetn <= 1'h0;
      imem_enable_init_pin <= 1'h0;
      high_vector_init_pin <= 1'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_reset(32'h00000078, `SCC_VEC_LOW);
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      finish_test();
   end
endmodule
